// file: sele_pkg.sv
// constants shared by the extra-lane enable logic
// assumes one 10 MHz system clock and a plain register port
//
// Overview of operation
// R1: link A bits 7..1 enable lanes A1..A7
// R2: link B bits 7..1 enable lanes B1..B7
// R3: mask honoured even if link mode unused
// R4: mask bit enables lane clocks only
// R5: link A bit 0 powers masked serializers
// R6: link B bit 0 powers masked serializers
// R7: serializer bit 0 keeps extra serializers off
// R8: serializer bit 1 lets extra lanes transmit
// R9: host writes only while serial interface off
// R10: lanes use shared link mode and pattern
// R11: extra lanes never override channel power-down
// R12: serializer needs all lower lanes enabled
// R13: both registers reset to zero
// R14: both channels down powers whole subsystem down
// R15: clocked lane without serializer drives nothing
package sele_pkg;

    // ==========================================================
    // register port
    // ==========================================================
    localparam int SELE_ADDR_W = 12;     // register address width
    localparam int SELE_DATA_W = 8;      // register data width
    localparam logic [11:0] SELE_OFS_LINK_A = 12'h20a; // link A register
    localparam logic [11:0] SELE_OFS_LINK_B = 12'h20b; // link B register

    // ==========================================================
    // fields and reset values
    // ==========================================================
    localparam int SELE_SER_BIT = 0;     // serializer-enable bit
    localparam int SELE_LANE_LSB = 1;    // lowest extra-lane bit
    localparam int SELE_LANE_MSB = 7;    // highest extra-lane bit
    localparam int SELE_NUM_LANES = 8;   // lanes per link, 0..7
    localparam logic [7:0] SELE_EXTRA_RST = 8'h00; // register reset
    localparam logic [7:0] SELE_RDATA_IDLE = 8'h00; // idle read data
    localparam int SELE_PD_A = 0;        // channel A power-down bit
    localparam int SELE_PD_B = 1;        // channel B power-down bit

    // ==========================================================
    // helpers
    // ==========================================================
    // bit n is set only if bits 0..n of the mask are all set
    function automatic logic [7:0] sele_prefix_mask(input logic [7:0] m);
        logic [7:0] p;
        p = 8'h00;
        p[0] = m[0];
        for (int i = 1; i < 8; i++) begin
            p[i] = p[i-1] & m[i];
        end
        return p;
    endfunction : sele_prefix_mask

endpackage : sele_pkg

// file: sele_lane_gate.sv
// per-link lane gating: lane clocks and serializer power
// assumes mode lanes come from the link-mode decoder of the device
`timescale 1ns/100ps
module sele_lane_gate import sele_pkg::*; (
    input wire logic [7:0] mode_lanes,
    input wire logic [7:0] extra_reg,
    input wire logic link_up,
    output logic [7:0] lane_clk_en,
    output logic [7:0] ser_on
);

    // ==========================================================
    // decode
    // ==========================================================
    wire logic [7:0] extra_lanes; // lanes asked for by the mask
    wire logic [7:0] ser_req; // lanes whose serializer is wanted
    wire logic [7:0] ser_clk_ok; // lanes with a clocked lower chain
    wire logic ser_bit; // serializer-enable field

    // mask lanes 1..7, lane 0 always belongs to the link mode
    assign extra_lanes = {extra_reg[SELE_LANE_MSB:SELE_LANE_LSB], 1'b0}; // [R1] [R2]
    assign ser_bit = extra_reg[SELE_SER_BIT];

    // mask adds clocks even where the mode has no lane; gated by power
    assign lane_clk_en = (mode_lanes | extra_lanes) & {8{link_up}}; // [R3] [R4] [R11]

    // extra serializers only with the serializer bit set
    assign ser_req = (mode_lanes | (ser_bit ? extra_lanes : 8'h00))
                     & lane_clk_en; // [R5] [R6] [R7] [R8]

    // a serializer gets its clock only through a gapless lower chain
    assign ser_clk_ok = sele_prefix_mask(lane_clk_en); // [R12]
    assign ser_on = ser_req & ser_clk_ok; // [R12] [R15]

endmodule : sele_lane_gate

// file: sele_extra_lane_top.sv
// extra-lane enable registers and lane gating for links A and B
// assumes a plain register port, synchronous inputs, one clock
`timescale 1ns/100ps
module sele_extra_lane_top import sele_pkg::*; #(
    parameter int MODE_W = 5,   // link-mode select width
    parameter int TEST_W = 4    // test-pattern select width
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic serial_if_enable,
    input wire logic [1:0] channel_power_down,
    input wire logic [MODE_W-1:0] link_mode_select,
    input wire logic [TEST_W-1:0] test_pattern_select,
    input wire logic [7:0] link_a_mode_lanes,
    input wire logic [7:0] link_b_mode_lanes,
    output logic [7:0] link_a_lane_clk_en,
    output logic [7:0] link_a_serializer_on,
    output logic [7:0] link_b_lane_clk_en,
    output logic [7:0] link_b_serializer_on,
    output logic subsystem_on,
    output logic [MODE_W-1:0] lane_mode,
    output logic [TEST_W-1:0] lane_test
);

    // ==========================================================
    // registers and decode
    // ==========================================================
    logic [7:0] link_a_extra_lane_enable; // link A mask and ser bit
    logic [7:0] link_b_extra_lane_enable; // link B mask and ser bit
    wire logic sel_a; // address hits link A register
    wire logic sel_b; // address hits link B register
    wire logic wr_ok; // write allowed: serial interface is off
    wire logic [7:0] next_rdata; // read data for the next cycle
    wire logic subsys_up; // whole serial subsystem powered
    wire logic link_a_up; // link A powered and running
    wire logic link_b_up; // link B powered and running
    wire logic [7:0] gate_a_clk; // link A lane clocks, unregistered
    wire logic [7:0] gate_a_ser; // link A serializers, unregistered
    wire logic [7:0] gate_b_clk; // link B lane clocks, unregistered
    wire logic [7:0] gate_b_ser; // link B serializers, unregistered

    assign sel_a = (reg_addr == SELE_OFS_LINK_A);
    assign sel_b = (reg_addr == SELE_OFS_LINK_B);

    // writes while the interface runs would retime live lanes
    assign wr_ok = reg_wr & ~serial_if_enable; // [R9]

    // unmapped addresses read as zero
    assign next_rdata = !reg_rd ? SELE_RDATA_IDLE :
                        sel_a ? link_a_extra_lane_enable :
                        sel_b ? link_b_extra_lane_enable :
                        SELE_RDATA_IDLE;

    // both channels down takes the pll and lmfc down too
    assign subsys_up = ~(channel_power_down[SELE_PD_A]
                         & channel_power_down[SELE_PD_B]); // [R14]

    // a link runs only with its channel powered
    assign link_a_up = serial_if_enable & subsys_up
                       & ~channel_power_down[SELE_PD_A]; // [R11] [R14]
    assign link_b_up = serial_if_enable & subsys_up
                       & ~channel_power_down[SELE_PD_B]; // [R11] [R14]

    // ==========================================================
    // register writes
    // ==========================================================
    // both registers clear on reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link_a_extra_lane_enable <= SELE_EXTRA_RST; // [R13]
        end else if (wr_ok && sel_a) begin
            link_a_extra_lane_enable <= reg_wdata; // [R1] [R5]
        end
    end

    // link B register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link_b_extra_lane_enable <= SELE_EXTRA_RST; // [R13]
        end else if (wr_ok && sel_b) begin
            link_b_extra_lane_enable <= reg_wdata; // [R2] [R6]
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= SELE_RDATA_IDLE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // lane gating per link
    // ==========================================================
    sele_lane_gate u_gate_a (
        .mode_lanes(link_a_mode_lanes),
        .extra_reg(link_a_extra_lane_enable),
        .link_up(link_a_up),
        .lane_clk_en(gate_a_clk),
        .ser_on(gate_a_ser)
    );

    sele_lane_gate u_gate_b (
        .mode_lanes(link_b_mode_lanes),
        .extra_reg(link_b_extra_lane_enable),
        .link_up(link_b_up),
        .lane_clk_en(gate_b_clk),
        .ser_on(gate_b_ser)
    );

    // ==========================================================
    // registered lane controls
    // ==========================================================
    // lane enables leave through flip-flops so no glitch reaches a lane
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            link_a_lane_clk_en <= 8'h00;
            link_a_serializer_on <= 8'h00;
            link_b_lane_clk_en <= 8'h00;
            link_b_serializer_on <= 8'h00;
        end else begin
            link_a_lane_clk_en <= gate_a_clk; // [R4]
            link_a_serializer_on <= gate_a_ser; // [R8] [R15]
            link_b_lane_clk_en <= gate_b_clk; // [R4]
            link_b_serializer_on <= gate_b_ser; // [R8] [R15]
        end
    end

    // subsystem power follows the channel power-downs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            subsystem_on <= 1'b0;
        end else begin
            subsystem_on <= subsys_up; // [R14]
        end
    end

    // every lane, extra or not, shares one rate and one pattern
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lane_mode <= '0;
            lane_test <= '0;
        end else begin
            lane_mode <= link_mode_select; // [R10]
            lane_test <= test_pattern_select; // [R10]
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    // a read strobe on link A and the data cycle after it
    sequence seq_read_a;
        reg_rd && sel_a ##1 1'b1;
    endsequence

    // a read strobe on link B and the data cycle after it
    sequence seq_read_b;
        reg_rd && sel_b ##1 1'b1;
    endsequence

    // a write to link A while the interface is running
    sequence seq_blocked_wr_a;
        reg_wr && sel_a && serial_if_enable;
    endsequence

    // both registers are zero right after reset
    AST_RESET_ZERO: assert property (@(posedge clk_sys) // [R13]
        !rst_n |=> (link_a_extra_lane_enable == 8'h00)
                   && (link_b_extra_lane_enable == 8'h00))
        else $error("extra-lane registers not cleared by reset");

    // every set mask bit of link A clocks its lane
    AST_A_MASK_CLK: assert property (@(posedge clk_sys) // [R1]
        disable iff (!rst_n)
        link_a_up |=> ((link_a_lane_clk_en[7:1]
                        & $past(link_a_extra_lane_enable[7:1]))
                       == $past(link_a_extra_lane_enable[7:1])))
        else $error("link A mask bit did not clock its lane");

    // every set mask bit of link B clocks its lane while the mode uses lane 0 only
    AST_B_MASK_CLK: assert property (@(posedge clk_sys) // [R2]
        disable iff (!rst_n)
        link_b_up && link_b_mode_lanes == 8'h01
        |=> ((link_b_lane_clk_en[7:1]
              & $past(link_b_extra_lane_enable[7:1]))
             == $past(link_b_extra_lane_enable[7:1])))
        else $error("link B mask bit did not clock its lane");

    // with the serializer bit low no extra lane serializes
    AST_A_SER_OFF: assert property (@(posedge clk_sys) // [R7]
        disable iff (!rst_n)
        !link_a_extra_lane_enable[SELE_SER_BIT]
        |=> ((link_a_serializer_on & ~$past(link_a_mode_lanes)) == 8'h00))
        else $error("link A extra serializer on with serializer bit low");

    // link A: lane 1 transmits once lane 0 runs and both bits set
    AST_A_SER_ON: assert property (@(posedge clk_sys) // [R5]
        disable iff (!rst_n)
        link_a_up && link_a_mode_lanes[0]
        && link_a_extra_lane_enable[1:0] == 2'b11
        |=> link_a_serializer_on[1] && link_a_lane_clk_en[1])
        else $error("link A extra serializer not powered");

    // link B: same premise, checks the lane 1 serializer only
    AST_B_SER_ON: assert property (@(posedge clk_sys) // [R6]
        disable iff (!rst_n)
        link_b_up && link_b_mode_lanes[0]
        && link_b_extra_lane_enable[1:0] == 2'b11
        |=> link_b_serializer_on[1])
        else $error("link B extra serializer not powered");

    // a serializer runs only over a gapless chain of lower clocks
    AST_CONTIGUOUS: assert property (@(posedge clk_sys) // [R12]
        disable iff (!rst_n)
        (link_a_serializer_on
         & ~sele_prefix_mask(link_a_lane_clk_en)) == 8'h00
        && (link_b_serializer_on
            & ~sele_prefix_mask(link_b_lane_clk_en)) == 8'h00)
        else $error("serializer on above a gap in lane clocks");

    // channel A power-down silences every link A lane
    AST_PD_WINS: assert property (@(posedge clk_sys) // [R11]
        disable iff (!rst_n)
        channel_power_down[SELE_PD_A]
        |=> link_a_lane_clk_en == 8'h00 && link_a_serializer_on == 8'h00)
        else $error("link A lane active under channel power-down");

    // both channels down drops the subsystem for two cycles held
    AST_SUBSYS_DOWN: assert property (@(posedge clk_sys) // [R14]
        disable iff (!rst_n)
        (&channel_power_down) [*2]
        |-> !subsystem_on && link_b_lane_clk_en == 8'h00)
        else $error("subsystem still on with both channels down");

    // writes while running leave the register untouched
    AST_WR_GUARD: assert property (@(posedge clk_sys) // [R9]
        disable iff (!rst_n)
        seq_blocked_wr_a |=> $stable(link_a_extra_lane_enable))
        else $error("link A register changed while interface enabled");

    // read of link A returns the register one cycle later
    AST_READ_A: assert property (@(posedge clk_sys) // [R1]
        disable iff (!rst_n)
        seq_read_a |-> reg_rdata == $past(link_a_extra_lane_enable))
        else $error("link A read data wrong");

    // read of link B returns the register one cycle later
    AST_READ_B: assert property (@(posedge clk_sys) // [R2]
        disable iff (!rst_n)
        seq_read_b |-> reg_rdata == $past(link_b_extra_lane_enable))
        else $error("link B read data wrong");

    // lanes follow the shared mode and pattern one cycle later
    AST_SHARED_MODE: assert property (@(posedge clk_sys) // [R10]
        disable iff (!rst_n)
        rst_n |=> lane_mode == $past(link_mode_select)
                 && lane_test == $past(test_pattern_select))
        else $error("lane mode or pattern not taken from link settings");

    // a lane without clock never has its serializer on
    AST_NO_STRAY: assert property (@(posedge clk_sys) // [R15]
        disable iff (!rst_n)
        (link_a_serializer_on & ~link_a_lane_clk_en) == 8'h00
        && (link_b_serializer_on & ~link_b_lane_clk_en) == 8'h00)
        else $error("serializer on for an unclocked lane");

endmodule : sele_extra_lane_top

// file: sele_rx_model.sv
// far-side receiver model for one link: counts lanes that carry data
// assumes lane outputs of one link, sampled on the system clock
`timescale 1ns/100ps
module sele_rx_model (
    input wire logic clk_sys,
    input wire logic [7:0] lane_clk_en,
    input wire logic [7:0] serializer_on,
    output logic [3:0] rx_lanes,
    output logic rx_gap
);
    // ==========================================================
    // lane capture
    // ==========================================================
    // a lane carries data only with clock and serializer both on
    wire logic [7:0] live = lane_clk_en & serializer_on;

    // count the live lanes; flag a hole below any live lane
    always_ff @(posedge clk_sys) begin
        rx_lanes <= 4'($countones(live));
        rx_gap <= (((live + 8'h01) & live) != 8'h00);
    end
endmodule : sele_rx_model

// file: testbench.sv
// self-checking bench for the extra-lane enable registers
// assumes the register port of the top module and 10 MHz clock
`timescale 1ns/100ps
module testbench import sele_pkg::*;;
    // ==========================================================
    // signals
    // ==========================================================
    logic clk_sys = 1'b0; // system clock
    logic rst_n = 1'b0; // synchronous reset, active low
    logic [11:0] reg_addr = 12'h000; // register address
    logic [7:0] reg_wdata = 8'h00; // write data
    logic reg_wr = 1'b0; // write strobe
    logic reg_rd = 1'b0; // read strobe
    logic [7:0] reg_rdata; // read data
    logic serial_if_enable = 1'b0; // serial interface enable
    logic [1:0] channel_power_down = 2'h0; // per-channel power-down
    logic [4:0] link_mode_select = 5'h00; // link mode
    logic [3:0] test_pattern_select = 4'h0; // test pattern
    logic [7:0] mode_a = 8'h00; // lanes link A mode needs
    logic [7:0] mode_b = 8'h00; // lanes link B mode needs
    logic [7:0] clk_a, ser_a, clk_b, ser_b; // lane outputs
    logic subsystem_on; // subsystem power
    logic [4:0] lane_mode; // registered mode copy
    logic [3:0] lane_test; // registered pattern copy
    logic [3:0] rx_a, rx_b; // lanes the receivers see
    logic gap_a, gap_b; // receiver hole flags
    logic [7:0] rd_val; // last read value
    int n_errors = 0; // mismatches
    int checked = 0; // comparisons

    // clock: 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // design and far-side receivers
    // ==========================================================
    sele_extra_lane_top #(.MODE_W(5), .TEST_W(4)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_if_enable(serial_if_enable),
        .channel_power_down(channel_power_down),
        .link_mode_select(link_mode_select),
        .test_pattern_select(test_pattern_select),
        .link_a_mode_lanes(mode_a), .link_b_mode_lanes(mode_b),
        .link_a_lane_clk_en(clk_a), .link_a_serializer_on(ser_a),
        .link_b_lane_clk_en(clk_b), .link_b_serializer_on(ser_b),
        .subsystem_on(subsystem_on), .lane_mode(lane_mode),
        .lane_test(lane_test)
    );
    sele_rx_model rx_link_a (.clk_sys(clk_sys), .lane_clk_en(clk_a),
        .serializer_on(ser_a), .rx_lanes(rx_a), .rx_gap(gap_a));
    sele_rx_model rx_link_b (.clk_sys(clk_sys), .lane_clk_en(clk_b),
        .serializer_on(ser_b), .rx_lanes(rx_b), .rx_gap(gap_b));

    // ==========================================================
    // tasks
    // ==========================================================
    // one compare, counted; mismatch reported at once
    task chk(input string what, input logic [7:0] exp,
             input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one-cycle write strobe
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data taken one edge after the edge closing its cycle
    task rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd

    // let register, lane outputs and receivers all update
    task settle;
        repeat (4) @(posedge clk_sys);
    endtask : settle

    // check both links and the receivers in one go
    task links(input logic [7:0] ca, sa, cb, sb,
               input logic [3:0] na, nb);
        chk("clk_a", ca, clk_a);
        chk("ser_a", sa, ser_a);
        chk("clk_b", cb, clk_b);
        chk("ser_b", sb, ser_b);
        chk("rx_a", {4'h0, na}, {4'h0, rx_a});
        chk("rx_b", {4'h0, nb}, {4'h0, rx_b});
    endtask : links

    // verdict, in one place
    task test_done;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // hang guard
    initial begin
        #200000;
        n_errors++;
        $display("ERROR watchdog expected end seen hang");
        test_done;
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(SELE_OFS_LINK_A, rd_val);
        chk("reg_a", SELE_EXTRA_RST, rd_val);
        rd(SELE_OFS_LINK_B, rd_val);
        chk("reg_b", SELE_EXTRA_RST, rd_val);
        rd(12'h20c, rd_val);
        chk("unmapped", 8'h00, rd_val);
        links(8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0);
        $display("test reset done");
        // serializers on for A, clocks only for B, B mode lane 0 absent
        mode_a <= 8'h01;
        wr(SELE_OFS_LINK_A, 8'h0f);
        wr(SELE_OFS_LINK_B, 8'h0e);
        rd(SELE_OFS_LINK_A, rd_val);
        chk("reg_a", 8'h0f, rd_val);
        rd(SELE_OFS_LINK_B, rd_val);
        chk("reg_b", 8'h0e, rd_val);
        link_mode_select <= 5'h13;
        test_pattern_select <= 4'h9;
        serial_if_enable <= 1'b1;
        settle;
        links(8'h0f, 8'h0f, 8'h0e, 8'h00, 4'h4, 4'h0);
        chk("lane_mode", 8'h13, {3'h0, lane_mode});
        chk("lane_test", 8'h09, {4'h0, lane_test});
        mode_b <= 8'h01;
        settle;
        links(8'h0f, 8'h0f, 8'h0f, 8'h01, 4'h4, 4'h1);
        $display("test lane enables done");
        // write while the serial interface runs is dropped
        wr(SELE_OFS_LINK_A, 8'h00);
        rd(SELE_OFS_LINK_A, rd_val);
        chk("reg_a", 8'h0f, rd_val);
        // hole in the A mask: serializers stop below the hole
        serial_if_enable <= 1'b0;
        wr(SELE_OFS_LINK_A, 8'h0b);
        wr(SELE_OFS_LINK_B, 8'hff);
        serial_if_enable <= 1'b1;
        settle;
        links(8'h0b, 8'h03, 8'hff, 8'hff, 4'h2, 4'h8);
        chk("gap", 8'h00, {6'h00, gap_a, gap_b});
        $display("test contiguous lanes done");
        // channel power-down wins over extra lanes
        channel_power_down <= 2'h1;
        settle;
        links(8'h00, 8'h00, 8'hff, 8'hff, 4'h0, 4'h8);
        chk("subsystem", 8'h01, {7'h00, subsystem_on});
        channel_power_down <= 2'h3;
        settle;
        links(8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0);
        chk("subsystem", 8'h00, {7'h00, subsystem_on});
        $display("test power-down done");
        // second reset clears the link B register
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(SELE_OFS_LINK_B, rd_val);
        chk("reg_b", SELE_EXTRA_RST, rd_val);
        $display("test second reset done");
        test_done;
    end
endmodule : testbench
